// file: pmu_pkg.sv
package pmu_pkg;

    // ----------------------------------------
    // Link rates and timing
    // ----------------------------------------
    localparam int SCL_MAX_KBPS = 400;
    localparam int REG_CLK_KHZ = 15;
    localparam int WR_GAP_REG_CYCLES = 3;

    // ----------------------------------------
    // Bus addresses
    // ----------------------------------------
    localparam logic [6:0] ADDR_SEL_HIGH = 7'h49;
    localparam logic [6:0] ADDR_SEL_LOW = 7'h48;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_BUS_ADDR = 8'h01;
    localparam logic [7:0] OFS_BTN_STATUS = 8'h02;
    localparam logic [7:0] OFS_BTN_CLEAR = 8'h03;
    localparam logic [7:0] OFS_BTN_IRQ_SET = 8'h04;
    localparam logic [7:0] OFS_BTN_IRQ_CLR = 8'h05;
    localparam logic [7:0] OFS_BTN_IRQ_MASK = 8'h06;
    localparam logic [7:0] OFS_IRQ_SET = 8'h08;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h09;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0a;
    localparam logic [7:0] OFS_IRQ_CAUSE = 8'h0b;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int IRQ_GLOBAL_BIT = 7;
    localparam int IRQ_RTC_BIT = 0;
    localparam int IRQ_BTN_BIT = 1;
    localparam int IRQ_PWR_BIT = 2;
    localparam int IRQ_BOOST_BIT = 3;
    localparam int IRQ_BUCK_BIT = 4;
    localparam int IRQ_SOURCES = 5;
    localparam int BTN_LOW_BIT = 0;
    localparam int BTN_HIGH_BIT = 1;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;
    localparam logic [4:0] IRQ_CAUSE_RST = 5'h00;
    localparam logic [1:0] BTN_RST = 2'h0;

    // ----------------------------------------
    // Protocol states
    // ----------------------------------------
    typedef enum logic [2:0] {
        PMU_IDLE = 3'h0,
        PMU_DEV = 3'h1,
        PMU_REG = 3'h3,
        PMU_WDAT = 3'h2,
        PMU_RDAT = 3'h6,
        PMU_SKIP = 3'h7
    } pmu_state_e;

endpackage : pmu_pkg

// file: pmu_pin_sync.sv
module pmu_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // System side
    input wire logic clock,
    input wire logic rst,
    // Pins
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // ----------------------------------------
    // Three stages, change taken on agreement
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    s1_reg <= RST_VAL[i];
                    s2_reg <= RST_VAL[i];
                    s3_reg <= RST_VAL[i];
                    q[i] <= RST_VAL[i];
                end else begin
                    s1_reg <= d[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        q[i] <= s3_reg;
                    end
                end
            end
        end
    endgenerate

endmodule : pmu_pin_sync

// file: pmu_link_sampler.sv
module pmu_link_sampler (
    // Link side
    input wire logic link_clock,
    input wire logic rst,
    input wire logic serial_data_in,
    // Crossing toward the system clock
    output logic bit_val,
    output logic bit_tog
);

    // ----------------------------------------
    // Bit capture on the serial clock
    // ----------------------------------------
    // Value stays put for a whole bit period, so the toggle
    // alone needs synchronising on the far side
    always_ff @(posedge link_clock or posedge rst) begin
        if (rst) begin
            bit_val <= 1'b1;
            bit_tog <= 1'b0;
        end else begin
            bit_val <= serial_data_in;
            bit_tog <= ~bit_tog;
        end
    end

endmodule : pmu_link_sampler

// file: pmu_host_ctrl.sv
module pmu_host_ctrl (
    // System
    input wire logic clock,
    input wire logic rst,
    // Serial link
    input wire logic serial_clock_pin,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe_n,
    input wire logic address_select_pin,
    // Straps and event sources
    input wire logic fuse_alt,
    input wire logic button_pin,
    input wire logic rtc_alarm,
    input wire logic pwr_fail,
    input wire logic boost_fail,
    input wire logic buck_fail,
    // Interrupt
    output logic interrupt_ready_n
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [3:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic sel_s;
    logic btn_s;
    logic scl_q_reg;
    logic sda_q_reg;
    logic btn_q_reg;

    pmu_pin_sync #(.WIDTH(4), .RST_VAL(4'hf)) u_sync (
        .clock(clock),
        .rst(rst),
        .d({button_pin, address_select_pin, serial_data_pin_in, serial_clock_pin}),
        .q(pins_s)
    );

    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign sel_s = pins_s[2];
    assign btn_s = pins_s[3];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
            btn_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_s;
            sda_q_reg <= sda_s;
            btn_q_reg <= btn_s;
        end
    end

    // ----------------------------------------
    // Link clock domain and bit crossing
    // ----------------------------------------
    logic bit_val;
    logic bit_tog;
    logic tog_m_reg;
    logic tog_s_reg;
    logic tog_q_reg;
    logic bit_evt;

    pmu_link_sampler u_link (
        .link_clock(serial_clock_pin),
        .rst(rst),
        .serial_data_in(serial_data_pin_in),
        .bit_val(bit_val),
        .bit_tog(bit_tog)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tog_m_reg <= 1'b0;
            tog_s_reg <= 1'b0;
            tog_q_reg <= 1'b0;
        end else begin
            tog_m_reg <= bit_tog;
            tog_s_reg <= tog_m_reg;
            tog_q_reg <= tog_s_reg;
        end
    end

    assign bit_evt = tog_s_reg ^ tog_q_reg;

    // ----------------------------------------
    // Frame conditions and own address
    // ----------------------------------------
    logic start_det;
    logic stop_det;
    logic scl_fall;
    logic [6:0] my_addr;
    logic alt_reg;
    logic alt_done_reg;

    assign start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
    assign stop_det = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
    assign scl_fall = scl_q_reg & ~scl_s;
    assign my_addr = sel_s ? pmu_pkg::ADDR_SEL_HIGH : pmu_pkg::ADDR_SEL_LOW;

    // fuse strap capture
    // Caught after release so the reset itself only loads constants
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            alt_reg <= 1'b0;
            alt_done_reg <= 1'b0;
        end else if (!alt_done_reg) begin
            alt_reg <= fuse_alt;
            alt_done_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // Serial protocol engine
    // ----------------------------------------
    pmu_pkg::pmu_state_e state_reg;
    logic [3:0] cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] idx_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rd_data;
    logic [7:0] byte_in;
    logic ack_pend_reg;
    logic in_ack_reg;
    logic wr_stb_reg;
    logic rd_stb_reg;
    logic active;

    assign byte_in = {shift_reg[6:0], bit_val};
    assign active = (state_reg != pmu_pkg::PMU_IDLE) && (state_reg != pmu_pkg::PMU_SKIP);
    assign serial_data_pin_out = 1'b0;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= pmu_pkg::PMU_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            idx_reg <= 8'h00;
            wdata_reg <= 8'h00;
            ack_pend_reg <= 1'b0;
            in_ack_reg <= 1'b0;
            wr_stb_reg <= 1'b0;
            rd_stb_reg <= 1'b0;
            serial_data_pin_oe_n <= 1'b1;
        end else begin
            wr_stb_reg <= 1'b0;
            rd_stb_reg <= 1'b0;
            if (start_det) begin
                // start opens a frame, repeated start too
                state_reg <= pmu_pkg::PMU_DEV;
                cnt_reg <= 4'h0;
                ack_pend_reg <= 1'b0;
                in_ack_reg <= 1'b0;
                serial_data_pin_oe_n <= 1'b1;
            end else if (stop_det) begin
                state_reg <= pmu_pkg::PMU_IDLE;
                ack_pend_reg <= 1'b0;
                in_ack_reg <= 1'b0;
                serial_data_pin_oe_n <= 1'b1;
            end else if (bit_evt && active) begin
                if (in_ack_reg) begin
                    // Master refusing a read byte ends the read
                    if (state_reg == pmu_pkg::PMU_RDAT && bit_val) begin
                        state_reg <= pmu_pkg::PMU_SKIP;
                        in_ack_reg <= 1'b0;
                        serial_data_pin_oe_n <= 1'b1;
                    end
                end else begin
                    shift_reg <= byte_in;
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == 4'h7) begin
                        ack_pend_reg <= 1'b1;
                        unique case (state_reg)
                            pmu_pkg::PMU_DEV: begin
                                if (byte_in[7:1] == my_addr) begin
                                    state_reg <= byte_in[0] ? pmu_pkg::PMU_RDAT
                                                            : pmu_pkg::PMU_REG;
                                    // Count restarts so a read address still gets its ACK
                                    cnt_reg <= 4'h0;
                                end else begin
                                    state_reg <= pmu_pkg::PMU_SKIP;
                                    ack_pend_reg <= 1'b0;
                                end
                            end
                            pmu_pkg::PMU_REG: begin
                                idx_reg <= byte_in;
                                state_reg <= pmu_pkg::PMU_WDAT;
                            end
                            pmu_pkg::PMU_WDAT: begin
                                wdata_reg <= byte_in;
                                wr_stb_reg <= 1'b1;
                            end
                            pmu_pkg::PMU_RDAT: begin
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end else if (scl_fall && active) begin
                if (ack_pend_reg) begin
                    ack_pend_reg <= 1'b0;
                    in_ack_reg <= 1'b1;
                    serial_data_pin_oe_n <= (state_reg == pmu_pkg::PMU_RDAT) && (cnt_reg == 4'h8);
                end else if (in_ack_reg) begin
                    in_ack_reg <= 1'b0;
                    cnt_reg <= 4'h0;
                    if (state_reg == pmu_pkg::PMU_RDAT) begin
                        shift_reg <= rd_data;
                        rd_stb_reg <= 1'b1;
                        serial_data_pin_oe_n <= rd_data[7];
                    end else begin
                        serial_data_pin_oe_n <= 1'b1;
                    end
                end else if (state_reg == pmu_pkg::PMU_RDAT) begin
                    serial_data_pin_oe_n <= shift_reg[7];
                end
            end
        end
    end

    // ----------------------------------------
    // Button status
    // ----------------------------------------
    logic [1:0] btn_status_reg;
    logic [1:0] btn_ien_reg;
    logic [1:0] btn_clr;
    logic btn_evt;

    assign btn_clr = (wr_stb_reg && idx_reg == pmu_pkg::OFS_BTN_CLEAR) ? wdata_reg[1:0] : 2'h0;
    assign btn_evt = (btn_q_reg & ~btn_s & btn_ien_reg[pmu_pkg::BTN_LOW_BIT])
                   | (~btn_q_reg & btn_s & btn_ien_reg[pmu_pkg::BTN_HIGH_BIT]);

    // seen low and seen high, set wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            btn_status_reg <= pmu_pkg::BTN_RST;
        end else begin
            btn_status_reg <= (btn_status_reg & ~btn_clr) | {btn_s, ~btn_s};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            btn_ien_reg <= pmu_pkg::BTN_RST;
        end else if (wr_stb_reg && idx_reg == pmu_pkg::OFS_BTN_IRQ_SET) begin
            btn_ien_reg <= btn_ien_reg | wdata_reg[1:0];
        end else if (wr_stb_reg && idx_reg == pmu_pkg::OFS_BTN_IRQ_CLR) begin
            btn_ien_reg <= btn_ien_reg & ~wdata_reg[1:0];
        end
    end

    // ----------------------------------------
    // Interrupt controller
    // ----------------------------------------
    logic [7:0] irq_mask_reg;
    logic [4:0] cause_reg;
    logic [4:0] src_evt;
    logic [4:0] cause_set;
    logic [4:0] cause_ack;
    logic released_reg;
    logic cause_rd;

    assign src_evt = {buck_fail, boost_fail, pwr_fail, btn_evt, rtc_alarm};
    assign cause_set = src_evt & irq_mask_reg[pmu_pkg::IRQ_SOURCES-1:0];
    assign cause_ack = (wr_stb_reg && idx_reg == pmu_pkg::OFS_IRQ_CAUSE) ? wdata_reg[4:0] : 5'h0;
    assign cause_rd = rd_stb_reg && idx_reg == pmu_pkg::OFS_IRQ_CAUSE;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_mask_reg <= pmu_pkg::IRQ_MASK_RST;
        end else if (wr_stb_reg && idx_reg == pmu_pkg::OFS_IRQ_SET) begin
            irq_mask_reg <= irq_mask_reg | wdata_reg;
        end else if (wr_stb_reg && idx_reg == pmu_pkg::OFS_IRQ_CLR) begin
            irq_mask_reg <= irq_mask_reg & ~wdata_reg;
        end
    end

    // acknowledge by writing ones, a new event wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cause_reg <= pmu_pkg::IRQ_CAUSE_RST;
        end else begin
            cause_reg <= (cause_reg & ~cause_ack) | cause_set;
        end
    end

    // cause read releases pin until next event
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            released_reg <= 1'b0;
        end else if (|cause_set) begin
            released_reg <= 1'b0;
        end else if (cause_rd) begin
            released_reg <= 1'b1;
        end
    end

    // global and individual enable both needed
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            interrupt_ready_n <= 1'b1;
        end else begin
            interrupt_ready_n <= ~(irq_mask_reg[pmu_pkg::IRQ_GLOBAL_BIT] && !released_reg
                                   && |(cause_reg & irq_mask_reg[4:0]));
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        rd_data = 8'h00;
        unique case (idx_reg)
            // address in use and alternate flag
            pmu_pkg::OFS_BUS_ADDR: rd_data = {alt_reg, my_addr};
            pmu_pkg::OFS_BTN_STATUS: rd_data = {6'h00, btn_status_reg};
            pmu_pkg::OFS_BTN_IRQ_MASK: rd_data = {6'h00, btn_ien_reg};
            pmu_pkg::OFS_IRQ_MASK: rd_data = irq_mask_reg;
            pmu_pkg::OFS_IRQ_CAUSE: rd_data = {3'h0, cause_reg};
            default: rd_data = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_start;
        scl_s && scl_q_reg && sda_q_reg && !sda_s;
    endsequence

    property p_start_opens;
        @(posedge clock) disable iff (rst)
        s_start |=> state_reg == pmu_pkg::PMU_DEV && serial_data_pin_oe_n;
    endproperty
    a_start_opens: assert property (p_start_opens) else $error("start not taken");

    property p_global_off;
        @(posedge clock) disable iff (rst)
        !irq_mask_reg[pmu_pkg::IRQ_GLOBAL_BIT] |=> interrupt_ready_n;
    endproperty
    a_global_off: assert property (p_global_off) else $error("pin low without global");

    property p_mask_set;
        logic [7:0] d;
        @(posedge clock) disable iff (rst)
        (wr_stb_reg && idx_reg == pmu_pkg::OFS_IRQ_SET, d = wdata_reg)
        |=> (irq_mask_reg & d) == d && (irq_mask_reg & ~d) == ($past(irq_mask_reg) & ~d);
    endproperty
    a_mask_set: assert property (p_mask_set) else $error("mask set wrong");

    property p_mask_clr;
        logic [7:0] d;
        @(posedge clock) disable iff (rst)
        (wr_stb_reg && idx_reg == pmu_pkg::OFS_IRQ_CLR, d = wdata_reg)
        |=> (irq_mask_reg & d) == 8'h00 && (irq_mask_reg & ~d) == ($past(irq_mask_reg) & ~d);
    endproperty
    a_mask_clr: assert property (p_mask_clr) else $error("mask clear wrong");

    property p_reset_mask;
        @(posedge clock) disable iff (rst)
        $past(rst) |-> irq_mask_reg == 8'h00 && interrupt_ready_n;
    endproperty
    a_reset_mask: assert property (p_reset_mask) else $error("mask not cleared");

    property p_skip_quiet;
        @(posedge clock) disable iff (rst)
        state_reg == pmu_pkg::PMU_SKIP |-> serial_data_pin_oe_n;
    endproperty
    a_skip_quiet: assert property (p_skip_quiet) else $error("drive on foreign frame");

    property p_cause_release;
        @(posedge clock) disable iff (rst)
        cause_rd && !(|cause_set) ##1 !(|cause_set) |=> interrupt_ready_n;
    endproperty
    a_cause_release: assert property (p_cause_release) else $error("pin not released");

    property p_btn_low_seen;
        @(posedge clock) disable iff (rst)
        !btn_s |=> btn_status_reg[pmu_pkg::BTN_LOW_BIT];
    endproperty
    a_btn_low_seen: assert property (p_btn_low_seen) else $error("low not recorded");

endmodule : pmu_host_ctrl

// file: pmu_master_model.sv
module pmu_master_model (
    // Bus pins
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int Q = 40;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic sbit(input logic b, output logic r);
        #Q sda_low = ~b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
    endtask : sbit
    task automatic start();
        #Q sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
    endtask : start
    task automatic stop();
        #Q sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask : stop
    task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] q,
                        output logic a);
        for (int i = 7; i >= 0; i--) begin
            sbit(d[i], q[i]);
        end
        sbit(ma, a);
    endtask : xfer
    // address with write bit, index, data
    // write gap left out: far too long here, the device does not need it
    task automatic wr(input logic [6:0] dev, input logic [7:0] idx, dat, output logic ok);
        logic [7:0] q;
        logic a0, a1, a2;
        start();
        xfer({dev, 1'b0}, 1'b1, q, a0);
        xfer(idx, 1'b1, q, a1);
        xfer(dat, 1'b1, q, a2);
        stop();
        ok = ~(a0 | a1 | a2);
    endtask : wr
    // index, repeated start, read, final nack
    task automatic rd(input logic [6:0] dev, input logic [7:0] idx, output logic [7:0] d,
                      output logic ok);
        logic [7:0] q;
        logic a0, a1, a2, a3;
        start();
        xfer({dev, 1'b0}, 1'b1, q, a0);
        xfer(idx, 1'b1, q, a1);
        start();
        xfer({dev, 1'b1}, 1'b1, q, a2);
        xfer(8'hff, 1'b1, d, a3);
        stop();
        ok = ~(a0 | a1 | a2);
    endtask : rd
endmodule : pmu_master_model

// file: pmu_two_wire_slave_irq_regs_tb.sv
module pmu_two_wire_slave_irq_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic addr_sel = 1'b1;
    logic fuse_alt = 1'b0;
    logic button = 1'b1;
    logic [3:0] ev = 4'h0;
    logic scl, m_low, sda_out, oe_n, irq_n;
    wire sda;
    int error_cnt = 0;
    int checks = 0;
    assign sda = ~(m_low | (~oe_n & ~sda_out));
    pmu_host_ctrl i_dut (.clock(clock), .rst(rst), .serial_clock_pin(scl),
        .serial_data_pin_in(sda), .serial_data_pin_out(sda_out), .serial_data_pin_oe_n(oe_n),
        .address_select_pin(addr_sel), .fuse_alt(fuse_alt), .button_pin(button),
        .rtc_alarm(ev[3]), .pwr_fail(ev[2]), .boost_fail(ev[1]), .buck_fail(ev[0]),
        .interrupt_ready_n(irq_n));
    pmu_master_model i_master (.scl(scl), .sda_low(m_low), .sda(sda));
    initial begin
        forever #2.5 clock = ~clock;
    end
    task automatic chk(input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task automatic wrc(input logic [7:0] idx, dat);
        logic ok;
        i_master.wr(pmu_pkg::ADDR_SEL_HIGH, idx, dat, ok);
        chk({7'h00, ok}, 8'h01);
    endtask : wrc
    task automatic rdc(input logic [7:0] idx, exp);
        logic [7:0] d;
        logic ok;
        i_master.rd(pmu_pkg::ADDR_SEL_HIGH, idx, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask : rdc
    task automatic pls(input logic [3:0] v);
        @(posedge clock);
        ev <= v;
        @(posedge clock);
        ev <= 4'h0;
        repeat (5) @(posedge clock);
    endtask : pls
    task automatic t_reset();
        logic [7:0] d;
        logic ok;
        rdc(8'h0a, 8'h00);
        rdc(8'h01, {1'b0, pmu_pkg::ADDR_SEL_HIGH});
        rdc(8'h02, 8'h02);
        @(posedge clock);
        addr_sel <= 1'b0;
        repeat (10) @(posedge clock);
        i_master.rd(pmu_pkg::ADDR_SEL_LOW, 8'h01, d, ok);
        chk(d, {1'b0, pmu_pkg::ADDR_SEL_LOW});
        i_master.wr(pmu_pkg::ADDR_SEL_HIGH, 8'h08, 8'h01, ok);
        chk({7'h00, ok}, 8'h00);
        @(posedge clock);
        addr_sel <= 1'b1;
        repeat (10) @(posedge clock);
        rdc(8'h0a, 8'h00);
        $display("reset and address test done");
    endtask : t_reset
    task automatic t_mask();
        logic [7:0] ofs[4] = '{8'h08, 8'h08, 8'h08, 8'h09};
        logic [7:0] dat[4] = '{8'h05, 8'h00, 8'h80, 8'h01};
        logic [7:0] exp[4] = '{8'h05, 8'h05, 8'h85, 8'h84};
        for (int i = 0; i < 4; i++) begin
            wrc(ofs[i], dat[i]);
            rdc(8'h0a, exp[i]);
        end
        $display("mask test done");
    endtask : t_mask
    task automatic t_irq();
        logic [7:0] cause[4] = '{8'h01, 8'h04, 8'h08, 8'h10};
        pls(4'h8);
        chk({7'h00, irq_n}, 8'h01);
        pls(4'h4);
        chk({7'h00, irq_n}, 8'h00);
        rdc(8'h0b, 8'h04);
        chk({7'h00, irq_n}, 8'h01);
        wrc(8'h0b, 8'h04);
        rdc(8'h0b, 8'h00);
        wrc(8'h08, 8'h1b);
        for (int i = 0; i < 4; i++) begin
            pls(4'h8 >> i);
            chk({7'h00, irq_n}, 8'h00);
            rdc(8'h0b, cause[i]);
            wrc(8'h0b, cause[i]);
        end
        $display("interrupt test done");
    endtask : t_irq
    task automatic t_button();
        wrc(8'h04, 8'h01);
        rdc(8'h06, 8'h01);
        @(posedge clock);
        button <= 1'b0;
        repeat (10) @(posedge clock);
        chk({7'h00, irq_n}, 8'h00);
        rdc(8'h02, 8'h03);
        rdc(8'h0b, 8'h02);
        wrc(8'h03, 8'h03);
        rdc(8'h02, 8'h01);
        wrc(8'h05, 8'h01);
        rdc(8'h06, 8'h00);
        $display("button test done");
    endtask : t_button
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (10) @(posedge clock);
        t_reset();
        t_mask();
        t_irq();
        t_button();
        conclude();
    end
    // Whole run is about 190 us of bus traffic
    initial begin
        #400us;
        error_cnt++;
        conclude();
    end
endmodule : pmu_two_wire_slave_irq_regs_tb
